// ---- rtl/iora_analyser.sv ----
`timescale 1ns/100ps
`include "iora_regs.svh"
module iora_analyser #(
   parameter int DATA_W = 32,
   parameter int SEGS = 2,
   parameter int ADDR_W = 4,
   parameter int SEL_LO = 0, // lowest segment-select bit
   parameter int SEL_W = 0, // 0: no select bits
   parameter int GROUP_W = 16, // data bits per segment group
   parameter int SPARES = `IORA_SPARES_DFLT,
   parameter int LOG_W = 0, // address-logging bits per record
   parameter bit USE_NOREPAIR = 1'b0, // 1: no-repair code instead of alloc bit
   parameter logic [SEGS*8-1:0] SEG_LO = '0, // per segment low limit
   parameter logic [SEGS*8-1:0] SEG_HI = '1, // per segment high limit
   parameter logic [LOG_W*8+7:0] LOG_SEL = '0, // per log bit {mode[1:0],idx[5:0]}
   parameter logic [`IORA_CODE_W-1:0] NOREPAIR_CODE = '0,
   parameter int CODE_BASE = 0 // code of first group bit (1 for two-block variant)
) (
   input wire logic clk, // 20 MHz self-test clock
   input wire logic resetn, // async reset, active low
   input wire logic test_start, // pulse: new self-test run begins
   input wire logic cmp_valid, // comparator result valid this cycle
   input wire logic [DATA_W-1:0] cmp_fail, // per data bit mismatch
   input wire logic [ADDR_W-1:0] fail_addr, // column address of compare
   input wire logic shift_en, // shift registers out
   output logic [1:0] overall_repair_state, // 00/01/1x status
   output logic [SEGS*(`IORA_REC_W+LOG_W)-1:0] segment_spare_record, // records
   output logic shift_out // serial data out
);
   localparam int REC_W = `IORA_REC_W + LOG_W;
   localparam int CHAIN_W = 2 + SEGS * REC_W;
   localparam logic [1:0] LOG_ADDR = 2'h0;
   localparam logic [1:0] LOG_INV = 2'h1;
   localparam logic [1:0] LOG_ONE = 2'h2;
   // idle record: the no-repair code when one is set, else all clear
   localparam logic [REC_W-1:0] REC_IDLE =
      USE_NOREPAIR ? REC_W'(NOREPAIR_CODE) : REC_W'(`IORA_REC_RST);

   iora_pkg::iora_status_t stat_q, stat_d;
   logic [SEGS*REC_W-1:0] rec_q, rec_d;
   logic [SEGS*8-1:0] used_q, used_d;
   logic [SEGS-1:0] seg_hit, seg_err;
   logic [CHAIN_W-1:0] chain_q;
   logic shift_q;
   wire [7:0] sel_val = (SEL_W == 0) ? 8'h00 :
      8'((fail_addr >> SEL_LO) & ((ADDR_W'(1) << SEL_W) - ADDR_W'(1)));
   wire any_fail = cmp_valid && (|cmp_fail);
   logic [DATA_W-1:0] claimed_m;

   // data bits owned by a matching segment
   // a process, not a function, so that seg_hit changes wake it
   always_comb begin
      claimed_m = '0;
      for (int s = 0; s < SEGS; s++) begin
         if (seg_hit[s]) begin
            claimed_m = claimed_m |
               (DATA_W'({GROUP_W{1'b1}}) << ((s % (DATA_W / GROUP_W)) * GROUP_W));
         end
      end
   end
   wire claimed_all = ~|(cmp_fail & ~claimed_m);

   // per segment analysis
   genvar g;
   generate
      for (g = 0; g < SEGS; g++) begin : seg
         localparam int GB = (g % (DATA_W / GROUP_W)) * GROUP_W;
         logic [GROUP_W-1:0] grp;
         logic [3:0] code;
         logic [LOG_W:0] logv;
         logic [REC_W-1:0] nrec;
         logic [7:0] nused;
         logic multi, same;
         int cnt;
         assign seg_hit[g] = ((SEGS == 1) && (SEL_W == 0)) ||
            ((sel_val >= SEG_LO[g*8 +: 8]) && (sel_val <= SEG_HI[g*8 +: 8]));
         assign grp = cmp_fail[GB +: GROUP_W];
         always_comb begin
            code = '0;
            cnt = 0;
            for (int b = GROUP_W - 1; b >= 0; b--) begin
               if (grp[b]) begin
                  code = 4'(b + CODE_BASE);
                  cnt = cnt + 1;
               end
            end
         end
         assign multi = cnt > 1;
         always_comb begin
            logv = '0;
            for (int k = 0; k < LOG_W; k++) begin
               unique case (LOG_SEL[k*8+6 +: 2])
                  LOG_ADDR: logv[k] = fail_addr[LOG_SEL[k*8 +: 6] % ADDR_W];
                  LOG_INV: logv[k] = ~fail_addr[LOG_SEL[k*8 +: 6] % ADDR_W];
                  LOG_ONE: logv[k] = 1'b1;
                  default: logv[k] = 1'b0;
               endcase
            end
         end
         assign same = rec_q[g*REC_W +: `IORA_CODE_W] == code;
         // two failing IOs in one compare, or extra distinct IO with spares used
         assign seg_err[g] = seg_hit[g] && (|grp) &&
            (multi || (!same && (used_q[g*8 +: 8] >= 8'(SPARES))));
         // next record and spare count of this segment
         always_comb begin
            nrec = rec_q[g*REC_W +: REC_W];
            nused = used_q[g*8 +: 8];
            if (test_start) begin
               nrec = REC_IDLE;
               nused = 8'h00;
            end else if (cmp_valid && seg_hit[g] && (|grp) && !seg_err[g]) begin
               if (nused == 8'h00) begin
                  // log bits placed apart from code field
                  nrec = REC_W'(logv) << `IORA_REC_W;
                  // four code bits, alloc on top
                  nrec[`IORA_CODE_W-1:0] = code;
                  // allocation bit only without no-repair code
                  nrec[`IORA_ALLOC_BIT] = !USE_NOREPAIR;
               end
               // each distinct failing IO takes a spare
               if ((nused == 8'h00) || !same) begin
                  nused = nused + 8'h01;
               end
            end
         end
         // only the first spare gets a record; later ones are just counted
         assign rec_d[g*REC_W +: REC_W] = nrec;
         assign used_d[g*8 +: 8] = nused;
      end
   endgenerate

   always_comb begin
      stat_d = stat_q;
      if (test_start) begin
         stat_d = `IORA_ST_NONE;
      end else if (any_fail && ((|seg_err) || !claimed_all)) begin
         stat_d = `IORA_ST_FAIL;
      end else if (any_fail && !stat_q[1]) begin
         stat_d = `IORA_ST_NEED;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stat_q <= `IORA_ST_NONE;
         rec_q <= {SEGS{REC_IDLE}};
         used_q <= '0;
      end else begin
         stat_q <= stat_d;
         rec_q <= rec_d;
         used_q <= used_d;
      end
   end

   // serial unload of status and records
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         chain_q <= '0;
         shift_q <= 1'b0;
      end else if (shift_en) begin
         chain_q <= {1'b0, chain_q[CHAIN_W-1:1]};
         shift_q <= chain_q[0];
      end else begin
         chain_q <= {rec_d, stat_d};
         shift_q <= 1'b0;
      end
   end

   assign overall_repair_state = stat_q;
   assign segment_spare_record = rec_q;
   assign shift_out = shift_q;

   // unload leads with status bit 0
   chain_head_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(shift_en) |=> shift_out == $past(stat_q[0]))
      else $error("unload does not lead with status bit 0");

   // status leaves not-repairable only via a new run or a reset
   stat_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
      stat_q[1] && !test_start |=> stat_q[1])
      else $error("not repairable status dropped");
   start_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      test_start |=> (stat_q == `IORA_ST_NONE))
      else $error("status not cleared at start");
   fail_status_a: assert property (@(posedge clk) disable iff (!resetn)
      !test_start && any_fail && !claimed_all |=> stat_q == `IORA_ST_FAIL)
      else $error("unmatched failure not flagged");
   need_status_a: assert property (@(posedge clk) disable iff (!resetn)
      !test_start && any_fail && stat_q == `IORA_ST_NONE |=> stat_q != `IORA_ST_NONE)
      else $error("failure left status at no repair");
   alloc_bit_a: assert property (@(posedge clk) disable iff (!resetn)
      !USE_NOREPAIR && stat_q == `IORA_ST_NONE |-> ~|used_q)
      else $error("spare used without repair status");
   idle_code_a: assert property (@(posedge clk) disable iff (!resetn)
      test_start |=> ##1 (stat_q != `IORA_ST_NONE || !USE_NOREPAIR ||
         rec_q[`IORA_CODE_W-1:0] == NOREPAIR_CODE))
      else $error("no-repair code missing");
   seg_err_a: assert property (@(posedge clk) disable iff (!resetn)
      cmp_valid && !test_start && (|seg_err) |=> stat_q[1])
      else $error("spare overflow not flagged");
   used_cap_a: assert property (@(posedge clk) disable iff (!resetn)
      used_q[7:0] <= 8'(SPARES))
      else $error("spare count exceeded");
endmodule

// ---- rtl/iora_pkg.sv ----
package iora_pkg;
   typedef logic [1:0] iora_status_t;
   typedef logic [4:0] iora_rec_t;
endpackage

// ---- rtl/iora_regs.svh ----
`ifndef IORA_REGS_SVH
`define IORA_REGS_SVH
// repair status encodings
`define IORA_ST_NONE 2'h0
`define IORA_ST_NEED 2'h1
`define IORA_ST_FAIL 2'h2
// record layout for the IO-redundancy configuration
`define IORA_REC_W 5
`define IORA_CODE_W 4
`define IORA_ALLOC_BIT 4
`define IORA_REC_RST 5'h00
// default spares per segment
`define IORA_SPARES_DFLT 1
`endif

// ---- tb/iora_cmp_model.sv ----
`timescale 1ns/100ps
// comparator side: replays queued compare results back to back, one per cycle
module iora_cmp_model (
   input wire logic clk, // self-test clock
   input wire logic resetn, // async reset, active low
   output logic cmp_valid, // result valid
   output logic [31:0] cmp_fail, // per-bit mismatch
   output logic [3:0] fail_addr // column address
);
   logic [35:0] q [$];
   initial {cmp_valid, cmp_fail, fail_addr} = '0;
   task automatic push(input logic [31:0] v, input logic [3:0] a);
      q.push_back({a, v});
   endtask
   // idle lines flip every cycle so stale data never passes for a result
   always @(negedge clk or negedge resetn) begin
      if (!resetn) begin
         cmp_valid <= 1'b0;
         cmp_fail <= 32'h0;
      end else if (q.size() != 0) begin
         cmp_valid <= 1'b1;
         {fail_addr, cmp_fail} <= q.pop_front();
      end else begin
         cmp_valid <= 1'b0;
         cmp_fail <= ~cmp_fail;
         fail_addr <= ~fail_addr;
      end
   end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
   logic clk, resetn, test_start, shift_en, cmp_valid, shift_out;
   logic [31:0] cmp_fail, lfsr;
   logic [3:0] fail_addr;
   logic [1:0] overall_repair_state;
   logic [9:0] segment_spare_record;
   logic [11:0] got;
   logic [1:0] alt_state;
   logic [13:0] alt_rec;
   logic [3:0] aa;
   int error_cnt, cmp_count, b1, b2;
   int c1 [4] = '{0, 16, 15, 31};
   int c2 [4] = '{15, 31, 15, 0};
   iora_analyser iora_analyser_i (.clk(clk), .resetn(resetn), .test_start(test_start),
      .cmp_valid(cmp_valid), .cmp_fail(cmp_fail), .fail_addr(fail_addr), .shift_en(shift_en),
      .overall_repair_state(overall_repair_state),
      .segment_spare_record(segment_spare_record), .shift_out(shift_out));
   iora_cmp_model iora_cmp_model_i (.clk(clk), .resetn(resetn), .cmp_valid(cmp_valid),
      .cmp_fail(cmp_fail), .fail_addr(fail_addr));
   // second build: segment chosen by address bit 3, no-repair code f,
   // log bit 0 = inverse of address bit 0, log bit 1 = address bit 2
   if (1'h1) begin : alt
      iora_analyser #(.SEL_LO(3), .SEL_W(1), .LOG_W(2), .USE_NOREPAIR(1'h1),
         .SEG_LO(16'h0100), .SEG_HI(16'h0100), .LOG_SEL(24'h000240), .NOREPAIR_CODE(4'hf))
         iora_analyser_i (.clk(clk), .resetn(resetn), .test_start(test_start),
         .cmp_valid(cmp_valid), .cmp_fail(cmp_fail), .fail_addr(fail_addr), .shift_en(shift_en),
         .overall_repair_state(alt_state), .segment_spare_record(alt_rec), .shift_out());
   end
   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // chain {seg1, seg0, status} after two single-bit failures, f1 first
   function automatic logic [11:0] expect2(input int f1, input int f2);
      logic [4:0] r [2];
      logic [1:0] st;
      r[0] = 5'h00;
      r[1] = 5'h00;
      r[f1 / 16] = {1'b1, 4'(f1 % 16)};
      st = 2'h1;
      if (f2 / 16 != f1 / 16) r[f2 / 16] = {1'b1, 4'(f2 % 16)};
      else if (f2 != f1) st = 2'h2;
      return {r[1], r[0], st};
   endfunction
   // second build after one single-bit failure f at address a: {seg1, seg0, status}
   function automatic logic [15:0] alt_exp(input int f, input logic [3:0] a);
      logic [6:0] r [2];
      r[0] = 7'h0f;
      r[1] = 7'h0f;
      if (f / 16 != int'(a[3])) return {r[1], r[0], 2'h2};
      r[a[3]] = {a[2], ~a[0], 1'h0, 4'(f % 16)};
      return {r[1], r[0], 2'h1};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic start();
      @(negedge clk) test_start = 1'b1;
      @(negedge clk) test_start = 1'b0;
   endtask
   // first bit shows one edge after shift_en rises, status bit0 leading
   task automatic shift_chain();
      @(negedge clk) shift_en = 1'b1;
      for (int i = 0; i < 12; i++) begin
         @(negedge clk) got[i] = shift_out;
      end
      shift_en = 1'b0;
   endtask
   task automatic final_report();
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #(50 * 20000);
      error_cnt++;
      final_report();
   end
   initial begin
      resetn = 1'b0;
      test_start = 1'b0;
      shift_en = 1'b0;
      lfsr = 32'h0001208c;
      repeat (5) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      // run with no failure logs nothing
      start();
      repeat (3) @(negedge clk);
      check({segment_spare_record, overall_repair_state}, 12'h000);
      check({alt_rec, alt_state}, {7'h0f, 7'h0f, 2'h0});
      // corner pairs first, then random pairs at random addresses
      for (int t = 0; t < 16; t++) begin
         lfsr = next_rand(lfsr);
         b1 = (t < 4) ? c1[t] : int'(lfsr[4:0]);
         b2 = (t < 4) ? c2[t] : int'(lfsr[12:8]);
         start();
         // queue on the rising edge, clear of the model's falling-edge pop
         @(posedge clk);
         iora_cmp_model_i.push(32'h1 << b1, lfsr[19:16]);
         iora_cmp_model_i.push(32'h1 << b2, lfsr[23:20]);
         repeat (4) @(negedge clk);
         check({segment_spare_record, overall_repair_state}, expect2(b1, b2));
         shift_chain();
         check(got, expect2(b1, b2));
      end
      // second build: single failures, corner hit and miss first; bit 15 skipped,
      // its code would equal that build's no-repair code
      for (int t = 0; t < 8; t++) begin
         lfsr = next_rand(lfsr);
         b1 = (t < 2) ? 20 : int'(lfsr[4:0]);
         if (b1 % 16 == 15) b1 = b1 - 1;
         aa = (t == 0) ? 4'hd : (t == 1) ? 4'h2 : lfsr[19:16];
         start();
         check({alt_rec, alt_state}, {7'h0f, 7'h0f, 2'h0});
         @(posedge clk);
         iora_cmp_model_i.push(32'h1 << b1, aa);
         repeat (4) @(negedge clk);
         check({alt_rec, alt_state}, alt_exp(b1, aa));
         check({segment_spare_record, overall_repair_state}, expect2(b1, b1));
      end
      // two bits of one half failing in the same compare
      start();
      @(posedge clk);
      iora_cmp_model_i.push(32'h00030000, 4'h5);
      repeat (4) @(negedge clk);
      check(overall_repair_state, 2'h2);
      // reset in mid-run clears at once
      resetn = 1'b0;
      #5 check({segment_spare_record, overall_repair_state}, 12'h000);
      check({alt_rec, alt_state}, {7'h0f, 7'h0f, 2'h0});
      @(negedge clk) resetn = 1'b1;
      // first compare after release is taken with no new start
      @(posedge clk);
      iora_cmp_model_i.push(32'h8, 4'h0);
      repeat (3) @(negedge clk);
      check({segment_spare_record, overall_repair_state}, expect2(3, 3));
      check({alt_rec, alt_state}, alt_exp(3, 4'h0));
      final_report();
   end
endmodule
